// File: rtl/dcc_pkg.sv
// Constants, field layouts and carrier types of the dual comparator control block.
// Operation
// RL1: Both result bits sit in bits 7 and 6 and ignore software writes.
// RL2: Result reads 1 when plus input exceeds minus, reversed by its invert bit.
// RL3: Input switch picks minus inputs in modes 001 and 010.
// RL4: Mode 010 steers the internal reference to both plus inputs.
// RL5: Mode 110 drives raw comparator results onto pins 3 and 4; the code drives the results after their invert bits.
// RL6: Port direction bits still gate the output enables of pins 3 and 4.
// RL7: Flag sets whenever a result differs from the value latched at last access.
// RL8: Any read or write of the control register ends the mismatch.
// RL9: Flag clears only by writing zero; writing one sets it.
// RL10: Interrupt request needs all three enables; flag sets regardless.
// RL11: A change exactly on a control register read may be missed.
// RL12: Comparators keep running in sleep; an enabled change wakes the device.
// RL13: Mode 111 switches both comparators off.
// RL14: Leaving sleep keeps every control register bit unchanged.
// RL15: Port reads return zero on pins the mode makes analog.
// RL16: Eight modes come from the three-bit mode field in bits 2 to 0.
// RL17: Software keeps the interrupt disabled while it changes the mode.
// RL18: Reset clears the control register, mode 000 makes all pins analog; the mask table makes only pins 0 to 3 analog.
// RL19: Pin mapping of the other modes lives in a lookup table.
package dcc_pkg;
   // --------------------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------------------
   localparam logic [7:0] ADDR_CMP_CTRL = 8'h1f;
   localparam logic [7:0] ADDR_FLAG = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h21;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h22;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h23;
   localparam logic [7:0] ADDR_PORT_IN = 8'h24;
   localparam logic [7:0] ADDR_PORT_DIR = 8'h25;
   localparam logic [7:0] ADDR_IRQ_GATES = 8'h26;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'hff;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // --------------------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------------------
   localparam int BIT_SECOND_RESULT = 7;
   localparam int BIT_FIRST_RESULT = 6;
   localparam int BIT_SECOND_INVERT = 5;
   localparam int BIT_FIRST_INVERT = 4;
   localparam int BIT_INPUT_SWITCH = 3;
   localparam int MODE_MSB = 2;
   localparam int PIN_FIRST_OUT = 3;
   localparam int PIN_SECOND_OUT = 4;
   localparam int GATE_PERIPH = 0;
   localparam int GATE_GLOBAL = 1;
   localparam int GATE_CMP = 2;
   localparam int STAT_CHANGE = 0;
   localparam int STAT_WAKE = 1;
   // --------------------------------------------------------------------------
   // Modes
   // --------------------------------------------------------------------------
   typedef enum logic [2:0] {
      DCC_MODE_RESET = 3'h0,
      DCC_MODE_SWITCHED_ONE = 3'h1,
      DCC_MODE_SWITCHED_REF = 3'h2,
      DCC_MODE_THREE = 3'h3,
      DCC_MODE_FOUR = 3'h4,
      DCC_MODE_FIVE = 3'h5,
      DCC_MODE_PIN_OUT = 3'h6,
      DCC_MODE_OFF = 3'h7
   } dcc_mode_t;
   // Analog pin masks per mode for pins 4..0; modes 000 and 111 make 0..3 analog.
   localparam int MASK_STRIDE = 8;
   localparam logic [63:0] ANALOG_MASK_TABLE = 64'h0f_0f_0f_0f_0f_0f_0f_0f;
   // Input selector codes for each comparator input.
   localparam logic [2:0] SEL_PIN0 = 3'h0;
   localparam logic [2:0] SEL_PIN1 = 3'h1;
   localparam logic [2:0] SEL_PIN2 = 3'h2;
   localparam logic [2:0] SEL_PIN3 = 3'h3;
   localparam logic [2:0] SEL_VREF = 3'h4;
   localparam logic [2:0] SEL_NONE = 3'h7;
   // --------------------------------------------------------------------------
   // Carriers
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dcc_bus_req_t;
   typedef struct packed {
      logic [2:0] first_plus;
      logic [2:0] first_minus;
      logic [2:0] second_plus;
      logic [2:0] second_minus;
      logic first_on;
      logic second_on;
   } dcc_analog_sel_t;
endpackage

// File: rtl/dcc_top.sv
// Register, flag, routing and interrupt logic of the dual comparator control block.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module dcc_top (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire dcc_pkg::dcc_bus_req_t bus_req,
   output logic [7:0] rdata,
   input wire logic first_cmp_raw,
   input wire logic second_cmp_raw,
   input wire logic [4:0] port_a_pin_in,
   input wire logic sleep_active,
   output dcc_pkg::dcc_analog_sel_t analog_sel,
   output logic [4:0] port_a_pin_out,
   output logic [4:0] port_a_pin_oe,
   output logic cmp_irq,
   output logic wake_req,
   output logic irq
);
   import dcc_pkg::*;

   // --------------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------------
   logic [5:0] ctrl;
   logic [5:0] next_ctrl;
   logic [1:0] latched;
   logic [1:0] next_latched;
   logic cmp_change_flag;
   logic next_cmp_change_flag;
   logic [2:0] gates;
   logic [2:0] next_gates;
   logic [7:0] port_a_direction;
   logic [7:0] next_port_a_direction;
   logic [1:0] status;
   logic [1:0] next_status;
   logic [1:0] enable;
   logic [1:0] next_enable;
   logic [7:0] next_rdata;
   logic [4:0] next_pin_out;
   logic [4:0] next_pin_oe;
   dcc_analog_sel_t next_sel;
   logic next_cmp_irq;
   logic next_wake;
   logic next_irq;
   logic [1:0] result;
   logic [2:0] mode_bits;
   dcc_mode_t mode;
   logic ctrl_access;
   logic mismatch;
   logic [4:0] analog_mask;

   // Results with inversion applied; mode 111 powers the comparators off.
   always_comb begin
      mode_bits = ctrl[MODE_MSB:0];
      mode = dcc_mode_t'(mode_bits);
      result[0] = (mode != DCC_MODE_OFF) && (first_cmp_raw ^ ctrl[BIT_FIRST_INVERT]); // RL2 RL13
      result[1] = (mode != DCC_MODE_OFF) && (second_cmp_raw ^ ctrl[BIT_SECOND_INVERT]); // RL2 RL13
      ctrl_access = (bus_req.wr || bus_req.rd) && (bus_req.addr == ADDR_CMP_CTRL);
      mismatch = (result != latched); // RL7
      analog_mask = ANALOG_MASK_TABLE[mode_bits * MASK_STRIDE +: 5]; // RL19
   end

   // --------------------------------------------------------------------------
   // Register file and change flag
   // --------------------------------------------------------------------------
   // Writes, access latch, and change flag with set winning over clear.
   always_comb begin
      next_ctrl = ctrl;
      next_gates = gates;
      next_port_a_direction = port_a_direction;
      next_enable = enable;
      next_latched = latched;
      next_cmp_change_flag = cmp_change_flag;
      next_status = status;
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            ADDR_CMP_CTRL: next_ctrl = bus_req.wdata[5:0]; // RL1 RL16
            ADDR_FLAG: next_cmp_change_flag = bus_req.wdata[0]; // RL9
            ADDR_IRQ_CLEAR: next_status = status & ~bus_req.wdata[1:0];
            ADDR_IRQ_ENABLE: next_enable = bus_req.wdata[1:0];
            ADDR_PORT_DIR: next_port_a_direction = bus_req.wdata;
            ADDR_IRQ_GATES: next_gates = bus_req.wdata[2:0];
            default: next_ctrl = ctrl;
         endcase
      end
      if (ctrl_access) begin
         next_latched = result; // RL8 RL11
      end
      if (mismatch) begin
         next_cmp_change_flag = 1'b1; // RL7
         next_status[STAT_CHANGE] = 1'b1;
      end
      if (next_wake) begin
         next_status[STAT_WAKE] = 1'b1;
      end
   end

   // Register stage; sleep has no effect on any stored bit but the wake status bit.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= CTRL_RESET[5:0]; // RL18
         latched <= 2'h0;
         cmp_change_flag <= 1'b0;
         gates <= 3'h0;
         port_a_direction <= DIR_RESET;
         status <= 2'h0;
         enable <= 2'h0;
      end else begin
         ctrl <= next_ctrl; // RL14
         latched <= next_latched;
         cmp_change_flag <= next_cmp_change_flag;
         gates <= next_gates;
         port_a_direction <= next_port_a_direction;
         status <= next_status;
         enable <= next_enable;
      end
   end

   // --------------------------------------------------------------------------
   // Routing, read data and interrupts
   // --------------------------------------------------------------------------
   // Analog input selection, pin routing, read mux and interrupt outputs.
   always_comb begin
      next_sel.first_plus = SEL_PIN0;
      next_sel.first_minus = SEL_PIN0;
      next_sel.second_plus = SEL_PIN1;
      next_sel.second_minus = SEL_PIN1;
      next_sel.first_on = (mode != DCC_MODE_OFF) && (mode != DCC_MODE_RESET); // RL13 RL18
      next_sel.second_on = next_sel.first_on;
      unique case (mode)
         DCC_MODE_SWITCHED_ONE: begin
            next_sel.first_plus = SEL_PIN2;
            next_sel.first_minus = ctrl[BIT_INPUT_SWITCH] ? SEL_PIN3 : SEL_PIN0; // RL3
         end
         DCC_MODE_SWITCHED_REF: begin
            next_sel.first_plus = SEL_VREF; // RL4
            next_sel.second_plus = SEL_VREF; // RL4
            next_sel.first_minus = ctrl[BIT_INPUT_SWITCH] ? SEL_PIN3 : SEL_PIN0; // RL3
            next_sel.second_minus = ctrl[BIT_INPUT_SWITCH] ? SEL_PIN2 : SEL_PIN1; // RL3
         end
         DCC_MODE_RESET, DCC_MODE_OFF: begin
            next_sel.first_plus = SEL_NONE;
            next_sel.second_plus = SEL_NONE;
         end
         DCC_MODE_THREE, DCC_MODE_FOUR, DCC_MODE_FIVE, DCC_MODE_PIN_OUT: begin
            next_sel.first_plus = SEL_PIN2; // RL19
            next_sel.second_plus = SEL_PIN2;
         end
      endcase
      next_pin_out = 5'h00;
      next_pin_oe = 5'h00;
      if (mode == DCC_MODE_PIN_OUT) begin
         next_pin_out[PIN_FIRST_OUT] = result[0]; // RL5
         next_pin_out[PIN_SECOND_OUT] = result[1]; // RL5
         next_pin_oe[PIN_FIRST_OUT] = !port_a_direction[PIN_FIRST_OUT]; // RL6
         next_pin_oe[PIN_SECOND_OUT] = !port_a_direction[PIN_SECOND_OUT]; // RL6
      end
      next_rdata = ZERO_BYTE;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            ADDR_CMP_CTRL: next_rdata = {result[1], result[0], ctrl}; // RL1
            ADDR_FLAG: next_rdata = {7'h00, cmp_change_flag};
            ADDR_IRQ_STATUS: next_rdata = {6'h00, status};
            ADDR_IRQ_ENABLE: next_rdata = {6'h00, enable};
            ADDR_PORT_IN: next_rdata = {3'h0, port_a_pin_in & ~analog_mask}; // RL15
            ADDR_PORT_DIR: next_rdata = port_a_direction;
            ADDR_IRQ_GATES: next_rdata = {5'h00, gates};
            default: next_rdata = ZERO_BYTE;
         endcase
      end
      next_cmp_irq = cmp_change_flag && (&gates); // RL10
      next_wake = sleep_active && cmp_change_flag && gates[GATE_CMP]; // RL12
      next_irq = |(status & enable);
   end

   // Output stage.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         analog_sel <= '0;
         port_a_pin_out <= 5'h00;
         port_a_pin_oe <= 5'h00;
         rdata <= ZERO_BYTE;
         cmp_irq <= 1'b0;
         wake_req <= 1'b0;
         irq <= 1'b0;
      end else begin
         analog_sel <= next_sel;
         port_a_pin_out <= next_pin_out;
         port_a_pin_oe <= next_pin_oe;
         rdata <= next_rdata;
         cmp_irq <= next_cmp_irq;
         wake_req <= next_wake;
         irq <= next_irq;
      end
   end

   // --------------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------------
   property p_result_ro;
      @(posedge clk_sys) disable iff (!rst_b)
      bus_req.wr && bus_req.addr == ADDR_CMP_CTRL |=> ctrl == $past(bus_req.wdata[5:0]);
   endproperty
   a_result_ro: assert property (p_result_ro) else $error("Control write not stored."); // RL1

   property p_mismatch_flag;
      @(posedge clk_sys) disable iff (!rst_b)
      mismatch |=> cmp_change_flag;
   endproperty
   a_mismatch_flag: assert property (p_mismatch_flag) else $error("Mismatch did not set flag."); // RL7

   property p_access_latch;
      @(posedge clk_sys) disable iff (!rst_b)
      ctrl_access |=> latched == $past(result);
   endproperty
   a_access_latch: assert property (p_access_latch) else $error("Access did not latch results."); // RL8

   property p_flag_write;
      @(posedge clk_sys) disable iff (!rst_b)
      bus_req.wr && bus_req.addr == ADDR_FLAG && !mismatch |=> cmp_change_flag == $past(bus_req.wdata[0]);
   endproperty
   a_flag_write: assert property (p_flag_write) else $error("Flag write ignored."); // RL9

   property p_irq_gates;
      @(posedge clk_sys) disable iff (!rst_b)
      cmp_irq |-> $past(cmp_change_flag) && $past(&gates);
   endproperty
   a_irq_gates: assert property (p_irq_gates) else $error("Interrupt without enables."); // RL10

   property p_pin_route;
      @(posedge clk_sys) disable iff (!rst_b)
      mode == DCC_MODE_PIN_OUT && !port_a_direction[PIN_FIRST_OUT] |=> port_a_pin_oe[PIN_FIRST_OUT];
   endproperty
   a_pin_route: assert property (p_pin_route) else $error("Result not driven to pin."); // RL5 RL6

   property p_ref_plus;
      @(posedge clk_sys) disable iff (!rst_b)
      mode == DCC_MODE_SWITCHED_REF |=> analog_sel.first_plus == SEL_VREF && analog_sel.second_plus == SEL_VREF;
   endproperty
   a_ref_plus: assert property (p_ref_plus) else $error("Reference not routed."); // RL4

   property p_off_mode;
      @(posedge clk_sys) disable iff (!rst_b)
      mode == DCC_MODE_OFF |=> !analog_sel.first_on && !analog_sel.second_on;
   endproperty
   a_off_mode: assert property (p_off_mode) else $error("Off mode left comparators on."); // RL13

   // A control read returns both results in the top bits.
   property p_result_read;
      @(posedge clk_sys) disable iff (!rst_b)
      bus_req.rd && bus_req.addr == ADDR_CMP_CTRL |=> rdata[BIT_SECOND_RESULT:BIT_FIRST_RESULT] == $past(result);
   endproperty
   a_result_read: assert property (p_result_read) else $error("Result bits not read back."); // RL1 RL2

   // A control read in the off mode shows both results low.
   property p_off_read;
      @(posedge clk_sys) disable iff (!rst_b)
      bus_req.rd && bus_req.addr == ADDR_CMP_CTRL && mode == DCC_MODE_OFF
      |=> rdata[BIT_SECOND_RESULT:BIT_FIRST_RESULT] == 2'h0;
   endproperty
   a_off_read: assert property (p_off_read) else $error("Off mode results not low."); // RL13

   // The switch bit picks the first minus input in mode 001.
   property p_switch_one;
      @(posedge clk_sys) disable iff (!rst_b)
      mode == DCC_MODE_SWITCHED_ONE |=> analog_sel.first_minus == ($past(ctrl[BIT_INPUT_SWITCH]) ? SEL_PIN3 : SEL_PIN0);
   endproperty
   a_switch_one: assert property (p_switch_one) else $error("First minus input wrong."); // RL3

   // The switch bit picks the second minus input in mode 010.
   property p_switch_two;
      @(posedge clk_sys) disable iff (!rst_b)
      mode == DCC_MODE_SWITCHED_REF |=> analog_sel.second_minus == ($past(ctrl[BIT_INPUT_SWITCH]) ? SEL_PIN2 : SEL_PIN1);
   endproperty
   a_switch_two: assert property (p_switch_two) else $error("Second minus input wrong."); // RL3

   // Both pins carry their results in the pin output mode.
   property p_pin_value;
      @(posedge clk_sys) disable iff (!rst_b)
      mode == DCC_MODE_PIN_OUT |=> port_a_pin_out[PIN_SECOND_OUT:PIN_FIRST_OUT] == $past(result);
   endproperty
   a_pin_value: assert property (p_pin_value) else $error("Pin value differs from result."); // RL5

   // The second pin drives when its direction bit selects output.
   property p_second_oe;
      @(posedge clk_sys) disable iff (!rst_b)
      mode == DCC_MODE_PIN_OUT && !port_a_direction[PIN_SECOND_OUT] |=> port_a_pin_oe[PIN_SECOND_OUT];
   endproperty
   a_second_oe: assert property (p_second_oe) else $error("Second pin not driven."); // RL6

   // The first output pin is never driven while its direction bit selects input.
   property p_pin_tristate;
      @(posedge clk_sys) disable iff (!rst_b)
      port_a_direction[PIN_FIRST_OUT] |=> !port_a_pin_oe[PIN_FIRST_OUT];
   endproperty
   a_pin_tristate: assert property (p_pin_tristate) else $error("Input pin driven."); // RL6

   // The latched results move only on a control access.
   property p_latch_hold;
      @(posedge clk_sys) disable iff (!rst_b)
      !ctrl_access |=> latched == $past(latched);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("Latch moved without access."); // RL8

   // Nothing but a flag write can clear the flag.
   property p_flag_hold;
      @(posedge clk_sys) disable iff (!rst_b)
      cmp_change_flag && !(bus_req.wr && bus_req.addr == ADDR_FLAG) |=> cmp_change_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("Flag cleared without write."); // RL9

   // Writing one to the flag sets it.
   property p_flag_soft_set;
      @(posedge clk_sys) disable iff (!rst_b)
      bus_req.wr && bus_req.addr == ADDR_FLAG && bus_req.wdata[0] |=> cmp_change_flag;
   endproperty
   a_flag_soft_set: assert property (p_flag_soft_set) else $error("Soft flag set lost."); // RL9

   // A set flag with all gates open raises the request.
   property p_irq_raise;
      @(posedge clk_sys) disable iff (!rst_b)
      cmp_change_flag && (&gates) |=> cmp_irq;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("Interrupt not raised."); // RL10

   // Any closed gate keeps the request low.
   property p_irq_gate_off;
      @(posedge clk_sys) disable iff (!rst_b)
      !(&gates) |=> !cmp_irq;
   endproperty
   a_irq_gate_off: assert property (p_irq_gate_off) else $error("Interrupt with a gate closed."); // RL10

   // An enabled change during sleep wakes the device.
   property p_wake;
      @(posedge clk_sys) disable iff (!rst_b)
      sleep_active && cmp_change_flag && gates[GATE_CMP] |=> wake_req;
   endproperty
   a_wake: assert property (p_wake) else $error("No wake request."); // RL12

   // The control register changes only by its own write.
   property p_ctrl_hold;
      @(posedge clk_sys) disable iff (!rst_b)
      !(bus_req.wr && bus_req.addr == ADDR_CMP_CTRL) |=> ctrl == $past(ctrl);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("Control changed without write."); // RL14

   // Analog pins read back as zero.
   property p_port_analog;
      @(posedge clk_sys) disable iff (!rst_b)
      bus_req.rd && bus_req.addr == ADDR_PORT_IN |=> (rdata[4:0] & $past(analog_mask)) == 5'h00;
   endproperty
   a_port_analog: assert property (p_port_analog) else $error("Analog pin read nonzero."); // RL15

   // Every working mode powers both comparators.
   property p_mode_on;
      @(posedge clk_sys) disable iff (!rst_b)
      mode != DCC_MODE_OFF && mode != DCC_MODE_RESET |=> analog_sel.first_on && analog_sel.second_on;
   endproperty
   a_mode_on: assert property (p_mode_on) else $error("Working mode left comparators off."); // RL16

   // The reset mode keeps both comparators off.
   property p_reset_mode;
      @(posedge clk_sys) disable iff (!rst_b)
      mode == DCC_MODE_RESET |=> !analog_sel.first_on && !analog_sel.second_on;
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("Reset mode left comparators on."); // RL18

   c_change: cover property (@(posedge clk_sys) disable iff (!rst_b) mismatch ##1 cmp_irq);
   c_wake: cover property (@(posedge clk_sys) disable iff (!rst_b) wake_req);
   c_pin: cover property (@(posedge clk_sys) disable iff (!rst_b) port_a_pin_oe[PIN_SECOND_OUT]);
   c_soft_flag: cover property (@(posedge clk_sys) disable iff (!rst_b) bus_req.wr && bus_req.addr == ADDR_FLAG);
   c_ref_mode: cover property (@(posedge clk_sys) disable iff (!rst_b) mode == DCC_MODE_SWITCHED_REF);
endmodule
`default_nettype wire

// File: testbench/dcc_cpu_model.sv
// Register bus master and comparator source that sit beside the control block.
`timescale 1ns/100ps
`default_nettype none
module dcc_cpu_model (
   input wire logic clk_sys,
   input wire logic [7:0] rdata,
   output dcc_pkg::dcc_bus_req_t bus_req,
   output logic first_cmp_raw,
   output logic second_cmp_raw
);
   import dcc_pkg::*;
   // Bus idle and both comparators low until the first request.
   initial begin
      bus_req = '0;
      first_cmp_raw = 1'b0;
      second_cmp_raw = 1'b0;
   end
   // One-cycle write strobe; the block never makes the master wait.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask
   // A read of the control register also ends any pending mismatch.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req <= '0;
      #1 d = rdata;
   endtask
   // Comparator outputs settle promptly or after a chosen lag in cycles.
   task automatic set_raw(input logic a, input logic b, input int lag);
      @(posedge clk_sys);
      repeat (lag) @(posedge clk_sys);
      first_cmp_raw <= a;
      second_cmp_raw <= b;
   endtask
endmodule
`default_nettype wire

// File: testbench/dcc_top_bench.sv
// Self-checking bench of the dual comparator control block.
`timescale 1ns/100ps
`default_nettype none
module dcc_top_bench;
   import dcc_pkg::*;
   logic clk_sys, rst_b, r1, r2, sleep_active, cmp_irq, wake_req, irq;
   dcc_bus_req_t bus_req;
   logic [7:0] rdata, d, w;
   logic [4:0] pin_in, pin_out, pin_oe;
   dcc_analog_sel_t sel;
   logic e1, e2;
   int error_cnt, check_count, cycles, seed, m, g, r;
   dcc_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
      .first_cmp_raw(r1), .second_cmp_raw(r2), .port_a_pin_in(pin_in),
      .sleep_active(sleep_active), .analog_sel(sel), .port_a_pin_out(pin_out),
      .port_a_pin_oe(pin_oe), .cmp_irq(cmp_irq), .wake_req(wake_req), .irq(irq));
   dcc_cpu_model cpu (.clk_sys(clk_sys), .rdata(rdata), .bus_req(bus_req),
      .first_cmp_raw(r1), .second_cmp_raw(r2));
   // Free-running 250 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Cuts a hung run short.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // Compares one byte result and counts it.
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Main sequence; comparator gates stay off while modes change.
   initial begin
      seed = 64081;
      rst_b = 1'b0;
      sleep_active = 1'b0;
      pin_in = 5'h00;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      cpu.rd(ADDR_CMP_CTRL, d);
      chk("ctrl_reset", CTRL_RESET, d);
      cpu.rd(ADDR_PORT_DIR, d);
      chk("dir_reset", DIR_RESET, d);
      cpu.rd(8'h30, d);
      chk("unmapped", ZERO_BYTE, d);
      $display("test reset done");
      cpu.wr(ADDR_PORT_DIR, 8'h08);
      for (m = 0; m < 8; m++) begin
         r = $random(seed);
         w = {r[7:3], m[2:0]};
         cpu.set_raw(r[8], r[9], m % 3);
         pin_in <= r[14:10];
         cpu.wr(ADDR_CMP_CTRL, w ^ 8'hc0);
         repeat (4) @(posedge clk_sys);
         #1;
         e1 = (m == 7) ? 1'b0 : r[8] ^ w[4];
         e2 = (m == 7) ? 1'b0 : r[9] ^ w[5];
         if (m == 6) begin
            chk("pins", {6'h00, e2, e1}, {6'h00, pin_out[4:3]});
            chk("pin_oe", 8'h02, {6'h00, pin_oe[4:3]});
         end
         if (m == 1 || m == 2) begin
            chk("first_minus", {5'h00, w[3] ? SEL_PIN3 : SEL_PIN0}, {5'h00, sel.first_minus});
         end
         if (m == 2) begin
            chk("second_minus", {5'h00, w[3] ? SEL_PIN2 : SEL_PIN1}, {5'h00, sel.second_minus});
            chk("plus_vref", {2'b00, SEL_VREF, SEL_VREF}, {2'b00, sel.first_plus, sel.second_plus});
         end
         if (m == 7) begin
            chk("cmp_off", 8'h00, {6'h00, sel.first_on, sel.second_on});
         end
         chk("cmp_on", {6'h00, {2{m != 0 && m != 7}}}, {6'h00, sel.first_on, sel.second_on});
         cpu.rd(ADDR_CMP_CTRL, d);
         chk("ctrl", {e2, e1, w[5:0]}, d);
         cpu.rd(ADDR_PORT_IN, d);
         chk("port_analog", {3'h0, r[14], 4'h0}, d);
      end
      $display("test modes done");
      cpu.wr(ADDR_CMP_CTRL, 8'h02);
      cpu.rd(ADDR_CMP_CTRL, d);
      cpu.wr(ADDR_FLAG, 8'h00);
      cpu.rd(ADDR_FLAG, d);
      chk("flag_clear", 8'h00, {7'h00, d[0]});
      cpu.set_raw(~r1, ~r2, 1);
      repeat (4) @(posedge clk_sys);
      cpu.rd(ADDR_FLAG, d);
      chk("flag_set", 8'h01, {7'h00, d[0]});
      cpu.wr(ADDR_FLAG, 8'h00);
      cpu.rd(ADDR_FLAG, d);
      chk("flag_persist", 8'h01, {7'h00, d[0]});
      cpu.rd(ADDR_CMP_CTRL, d);
      cpu.wr(ADDR_FLAG, 8'h00);
      cpu.rd(ADDR_FLAG, d);
      chk("flag_ended", 8'h00, {7'h00, d[0]});
      cpu.wr(ADDR_FLAG, 8'h01);
      for (g = 0; g < 8; g++) begin
         cpu.wr(ADDR_IRQ_GATES, g[7:0]);
         repeat (3) @(posedge clk_sys);
         #1 chk("cmp_irq", {7'h00, g == 7}, {7'h00, cmp_irq});
      end
      cpu.rd(ADDR_FLAG, d);
      chk("flag_soft", 8'h01, {7'h00, d[0]});
      cpu.wr(ADDR_IRQ_ENABLE, 8'h01);
      repeat (3) @(posedge clk_sys);
      #1 chk("irq_on", 8'h01, {7'h00, irq});
      cpu.wr(ADDR_IRQ_ENABLE, 8'h00);
      repeat (3) @(posedge clk_sys);
      #1 chk("irq_masked", 8'h00, {7'h00, irq});
      cpu.set_raw(1'b0, 1'b0, 0);
      cpu.rd(ADDR_CMP_CTRL, d);
      chk("ctrl_low", 8'h02, d);
      cpu.wr(ADDR_FLAG, 8'h00);
      cpu.wr(ADDR_IRQ_CLEAR, 8'h03);
      cpu.rd(ADDR_IRQ_STATUS, d);
      chk("status_clear", 8'h00, {6'h00, d[1:0]});
      $display("test flag done");
      cpu.wr(ADDR_IRQ_GATES, 8'h04);
      @(posedge clk_sys);
      sleep_active <= 1'b1;
      cpu.set_raw(1'b1, 1'b0, 2);
      repeat (4) @(posedge clk_sys);
      #1 chk("wake", 8'h01, {7'h00, wake_req});
      cpu.rd(ADDR_IRQ_STATUS, d);
      chk("status_wake", 8'h03, {6'h00, d[1:0]});
      @(posedge clk_sys) sleep_active <= 1'b0;
      cpu.rd(ADDR_CMP_CTRL, d);
      chk("ctrl_after_sleep", 8'h42, d);
      $display("test sleep done");
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      cpu.rd(ADDR_CMP_CTRL, d);
      chk("ctrl_rereset", 8'h40, d);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
